// File: hdl/nbp_pkg.sv
// package: constants and carrier types for the nand protection host
package nbp_pkg;
  // ==========================================================
  // flash command codes
  localparam logic [7:0] CMD_PROT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_RESET       = 8'hff;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam int         PROT_ADDR_CYC   = 3;
  // ==========================================================
  // lock status byte fields
  localparam int LOCK_VOL_DOWN       = 0;
  localparam int LOCK_VOL_NOT_DOWN   = 1;
  localparam int LOCK_VOL_OPEN       = 2;
  localparam int LOCK_PERM_OPEN      = 3;
  localparam int LOCK_PERM_DOWN      = 4;
  localparam logic [7:0] LOCK_RESET  = 8'h0e;
  localparam logic [7:0] LOCK_RSVD_MASK = 8'he0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_WP_BIT    = 7;
  // ==========================================================
  // timing
  localparam int CLK_NS          = 10;
  localparam int PWRUP_VALID_US  = 100;
  localparam int INIT_BUSY_MS    = 2;
  localparam int WP_SETUP_NS     = 100;
  localparam int STROBE_NS       = 20;
  localparam int WHR_NS          = 60;
  localparam int PWRUP_CYC   = PWRUP_VALID_US * 1000 / CLK_NS;
  localparam int INIT_CYC    = INIT_BUSY_MS * 1000000 / CLK_NS;
  localparam int WP_CYC      = (WP_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CYC     = (WHR_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // software register map (byte offsets)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BLOCK  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LOCK   = 8'h0c;
  localparam logic [7:0] REG_DEVST  = 8'h10;
  localparam int CTRL_GO_PROT  = 0;
  localparam int CTRL_GO_RESET = 1;
  localparam int CTRL_GO_POLL  = 2;
  localparam int CTRL_WP_EN    = 3;
  localparam int CTRL_MULTI    = 4;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nbp_req_t;

  typedef struct packed {
    logic       ceN;
    logic       cle;
    logic       ale;
    logic       weN;
    logic       reN;
    logic       wpN;
    logic [7:0] ioOut;
    logic       ioOe_n;
  } nbp_pins_t;

  typedef enum logic [1:0] {BC_CMD, BC_ADDR, BC_READ} nbp_cyc_t;

  typedef struct packed {
    logic       go;
    nbp_cyc_t   kind;
    logic [7:0] data;
  } nbp_cycreq_t;
endpackage

// File: hdl/nbp_bus_cycle.sv
// one flash bus cycle: command latch, address latch or data read
`timescale 1ns/1ps
module nbp_bus_cycle (
  input  wire logic               clk_sys,  // system clock
  input  wire logic               nrst,     // async reset, low
  input  wire nbp_pkg::nbp_cycreq_t req,    // cycle request
  input  wire logic [7:0]         ioIn,     // flash data bus in
  output logic                    busy,     // cycle running
  output logic                    done,     // cycle finished pulse
  output logic [7:0]              rdData,   // byte read
  output logic                    cle,      // command latch enable
  output logic                    ale,      // address latch enable
  output logic                    weN,      // write strobe, low
  output logic                    reN,      // read strobe, low
  output logic [7:0]              ioOut,    // flash data bus out
  output logic                    ioOe_n    // bus enable, low drives
);
  import nbp_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} nbp_cst_t;
  typedef struct packed {
    nbp_cst_t   st;
    nbp_cyc_t   kind;
    logic [7:0] cnt;
    logic [7:0] data;
    logic [7:0] rd;
    logic       done;
  } nbp_cycstate_t;

  nbp_cycstate_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      CY_IDLE: begin
        if (req.go) begin
          next_s.st   = CY_LOW;
          next_s.kind = req.kind;
          next_s.data = req.data;
          next_s.cnt  = 8'(STROBE_CYC);
        end
      end
      CY_LOW: begin
        if (s.cnt <= 8'h01) begin
          if (s.kind == BC_READ) next_s.rd = ioIn;
          next_s.st  = CY_HIGH;
          next_s.cnt = 8'(STROBE_CYC);
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      CY_HIGH: begin
        if (s.cnt <= 8'h01) begin
          next_s.st   = CY_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: next_s.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{st: CY_IDLE, kind: BC_CMD, cnt: 8'h00, data: 8'h00,
             rd: 8'h00, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // latch enables held over the whole cycle for setup and hold
  assign busy   = (s.st != CY_IDLE);
  assign done   = s.done;
  assign rdData = s.rd;
  assign cle    = busy && (s.kind == BC_CMD);
  assign ale    = busy && (s.kind == BC_ADDR);
  assign weN    = !((s.st == CY_LOW) && (s.kind != BC_READ));
  assign reN    = !((s.st == CY_LOW) && (s.kind == BC_READ));
  assign ioOut  = s.data;
  assign ioOe_n = !(busy && (s.kind != BC_READ));
endmodule // nbp_bus_cycle

// File: hdl/nbp_delay.sv
// down-counter: loads a cycle count and flags when it has run out
`timescale 1ns/1ps
module nbp_delay (
  input  wire logic        clk_sys, // system clock
  input  wire logic        nrst,    // async reset, low
  input  wire logic        load,    // load count pulse
  input  wire logic [31:0] count,   // cycles to wait
  output logic             expired  // count ran out, level
);
  typedef struct packed {
    logic [31:0] cnt;
  } nbp_dlstate_t;

  nbp_dlstate_t s, next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = count;
    end else if (s.cnt != 32'h0) begin
      next_s.cnt = s.cnt - 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{cnt: 32'h0};
    end else begin
      s <= next_s;
    end
  end

  assign expired = (s.cnt == 32'h0) && !load;
endmodule // nbp_delay

// File: hdl/nbp_host.sv
// host controller: power-up reset, busy wait and block lock status query
//
// Functional notes
// - protection query is command 7Ah, three address cycles, one read.
// - block address split over three cycles as IO7..IO0 mapping shows.
// - first command after power-up is reset FFh, once ready valid.
// - detect end of busy by ready/busy or status read 70h/78h.
// - write protect kept low through power-up and power-down.
// - write protect high enables program/erase; set up 100 ns ahead.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module nbp_host #(
  parameter int PWRUP_WAIT = nbp_pkg::PWRUP_CYC, // ready/busy settle
  parameter int INIT_WAIT  = nbp_pkg::INIT_CYC   // init busy limit
) (
  input  wire logic              clk_sys, // system clock
  input  wire logic              nrst,    // async reset, low
  input  wire nbp_pkg::nbp_req_t swReq,   // software register request
  output logic [31:0]            swRdata, // read data, next cycle
  input  wire logic [7:0]        ioIn,    // flash data bus in
  input  wire logic              rbIn,    // ready/busy wire level
  output nbp_pkg::nbp_pins_t     pins     // flash control and bus out
);
  import nbp_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    H_PWRUP, H_IDLE, H_CMD, H_ADDR, H_WHR, H_READ,
    H_WAIT_RB, H_POLL_CMD, H_POLL_WHR, H_POLL_RD, H_WP_SETTLE
  } nbp_hst_t;

  typedef enum logic [1:0] {OP_PROT, OP_RESET, OP_POLL} nbp_op_t;

  typedef struct packed {
    nbp_hst_t    st;
    nbp_op_t     op;
    logic [1:0]  adrIdx;
    logic [11:0] block;
    logic [7:0]  lockSt;
    logic [7:0]  status;
    logic        wpEn;
    logic        multi;
    logic        initDone;
    logic        resetSent;
    logic        busy;
    logic        timeout;
    logic        pollMode;
    logic [31:0] rdata;
  } nbp_hstate_t;

  nbp_hstate_t s, next_s;

  nbp_cycreq_t cyc;
  logic        cycBusy;
  logic        cycDone;
  logic [7:0]  cycRd;
  logic        cle, ale, weN, reN, ioOe_n;
  logic [7:0]  ioOut;
  logic        dlLoad;
  logic [31:0] dlCount;
  logic        dlExp, pwrArm;
  logic [7:0]  adrByte;

  nbp_bus_cycle u_cyc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (cyc),
    .ioIn    (ioIn),
    .busy    (cycBusy),
    .done    (cycDone),
    .rdData  (cycRd),
    .cle     (cle),
    .ale     (ale),
    .weN     (weN),
    .reN     (reN),
    .ioOut   (ioOut),
    .ioOe_n  (ioOe_n)
  );

  nbp_delay u_dly (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (dlLoad),
    .count   (dlCount),
    .expired (dlExp)
  );

  // ==========================================================
  // address cycle mapping
  always_comb begin
    case (s.adrIdx)
      2'd0:    adrByte = {s.block[1:0], 6'h00};
      2'd1:    adrByte = s.block[9:2];
      2'd2:    adrByte = {6'h00, s.block[11:10]};
      default: adrByte = 8'h00;
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_s  = s;
    cyc     = '{go: 1'b0, kind: BC_CMD, data: 8'h00};
    dlLoad  = 1'b0;
    dlCount = 32'h0;

    // software register writes
    if (swReq.wr && swReq.addr == REG_CTRL) begin
      next_s.wpEn  = swReq.wdata[CTRL_WP_EN];
      next_s.multi = swReq.wdata[CTRL_MULTI];
    end
    if (swReq.wr && swReq.addr == REG_BLOCK) begin
      next_s.block = swReq.wdata[11:0];
    end

    case (s.st)
      H_PWRUP: begin
        // wait for ready/busy to become valid before anything
        if (pwrArm) begin
          dlLoad  = 1'b1;
          dlCount = 32'(PWRUP_WAIT);
        end else if (dlExp) begin
          next_s.st = H_IDLE;
        end
      end
      H_IDLE: begin
        next_s.busy = 1'b0;
        if (swReq.wr && swReq.addr == REG_CTRL) begin
          // nothing else goes out until the power-up reset
          if (swReq.wdata[CTRL_GO_RESET] || !s.resetSent) begin
            if (swReq.wdata[CTRL_GO_RESET]) begin
              next_s.op   = OP_RESET;
              next_s.st   = H_CMD;
              next_s.busy = 1'b1;
            end
          end else if (swReq.wdata[CTRL_GO_PROT] && s.initDone) begin
            next_s.op   = OP_PROT;
            next_s.st   = (s.wpEn || swReq.wdata[CTRL_WP_EN]) ? H_WP_SETTLE
                                                               : H_CMD;
            next_s.busy = 1'b1;
          end else if (swReq.wdata[CTRL_GO_POLL]) begin
            next_s.op   = OP_POLL;
            next_s.st   = H_POLL_CMD;
            next_s.busy = 1'b1;
          end
        end
      end
      H_WP_SETTLE: begin
        // write protect level settles before the next command
        if (dlExp) begin
          next_s.st = H_CMD;
        end
      end
      H_CMD: begin
        if (!cycBusy && !cycDone) begin
          cyc.go   = 1'b1;
          cyc.kind = BC_CMD;
          cyc.data = (s.op == OP_RESET) ? CMD_RESET
                                        : CMD_PROT_STATUS;
        end
        if (cycDone) begin
          next_s.adrIdx = 2'd0;
          if (s.op == OP_RESET) begin
            next_s.resetSent = 1'b1;
            next_s.timeout   = 1'b0;
            next_s.st        = H_WAIT_RB;
          end else begin
            next_s.st = H_ADDR;
          end
        end
      end
      H_ADDR: begin
        if (!cycBusy && !cycDone) begin
          cyc.go   = 1'b1;
          cyc.kind = BC_ADDR;
          cyc.data = adrByte;
        end
        if (cycDone) begin
          if (s.adrIdx == 2'(PROT_ADDR_CYC - 1)) begin
            next_s.st = H_WHR;
          end else begin
            next_s.adrIdx = s.adrIdx + 2'd1;
          end
        end
      end
      H_WHR: begin
        if (dlExp) begin
          next_s.st = H_READ;
        end
      end
      H_READ: begin
        if (!cycBusy && !cycDone) begin
          cyc.go   = 1'b1;
          cyc.kind = BC_READ;
        end
        if (cycDone) begin
          // reserved bits forced to zero
          // bits 4..0 kept as returned: lock-down, guards
          // permanent guard low = protected
          // volatile guard low = protected
          // bit 1 mirrors bit 0 inverted on a good part
          next_s.lockSt = cycRd & ~LOCK_RSVD_MASK;
          next_s.st  = H_IDLE;
        end
      end
      H_WAIT_RB: begin
        // init or reset busy: watch the open-drain line
        // only status read may be sent meanwhile
        if (dlExp) begin
          if (s.pollMode) begin
            next_s.st = H_POLL_CMD;
          end else if (rbIn) begin
            next_s.initDone = 1'b1; // read setup assumed
            next_s.st       = H_IDLE;
          end else begin
            next_s.timeout = 1'b1;  // overran the 2 ms limit
            next_s.st      = H_IDLE;
          end
        end else if (rbIn && !s.pollMode && !dlLoad) begin
          next_s.initDone = 1'b1;
          next_s.st       = H_IDLE;
        end
      end
      H_POLL_CMD: begin
        if (!cycBusy && !cycDone) begin
          cyc.go   = 1'b1;
          cyc.kind = BC_CMD;
          cyc.data = s.multi ? CMD_STATUS_ENH : CMD_STATUS;
        end
        if (cycDone) begin
          next_s.st = H_POLL_WHR;
        end
      end
      H_POLL_WHR: begin
        if (dlExp) begin
          next_s.st = H_POLL_RD;
        end
      end
      H_POLL_RD: begin
        if (!cycBusy && !cycDone) begin
          cyc.go   = 1'b1;
          cyc.kind = BC_READ;
        end
        if (cycDone) begin
          next_s.status = cycRd;
          // ready bit set: abort or init over
          if (cycRd[ST_READY_BIT]) begin
            next_s.initDone = 1'b1;
          end
          next_s.st = H_IDLE;
        end
      end
      default: next_s.st = H_IDLE;
    endcase

    // delay loads on entry to timed states
    if (next_s.st != s.st) begin
      case (next_s.st)
        H_WP_SETTLE: begin
          dlLoad  = 1'b1;
          dlCount = 32'(WP_CYC);
        end
        H_WHR, H_POLL_WHR: begin
          dlLoad  = 1'b1;
          dlCount = 32'(WHR_CYC);
        end
        H_WAIT_RB: begin
          dlLoad  = 1'b1;
          dlCount = 32'(INIT_WAIT);
        end
        default: begin
          dlLoad  = 1'b0;
          dlCount = 32'h0;
        end
      endcase
    end

    // read data, one cycle after the strobe
    next_s.rdata = 32'h0;
    if (swReq.rd) begin
      case (swReq.addr)
        REG_CTRL:   next_s.rdata = {27'h0, s.multi, s.wpEn, 3'h0};
        REG_BLOCK:  next_s.rdata = {20'h0, s.block};
        REG_STATUS: next_s.rdata = {27'h0, s.timeout, s.resetSent,
                                    s.initDone, rbIn, s.busy};
        REG_LOCK:   next_s.rdata = {24'h0, s.lockSt};
        REG_DEVST:  next_s.rdata = {24'h0, s.status};
        default:    next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{st: H_PWRUP, op: OP_PROT, adrIdx: 2'd0, block: 12'h000,
             lockSt: LOCK_RESET, status: 8'h00, wpEn: 1'b0, multi: 1'b0,
             initDone: 1'b0, resetSent: 1'b0, busy: 1'b1,
             timeout: 1'b0, pollMode: 1'b0, rdata: 32'h0};
    end else begin
      s <= next_s;
    end
  end

  // arms the power-up wait on the first edge after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwrArm <= 1'b1;
    end else begin
      pwrArm <= 1'b0;
    end
  end

  // ==========================================================
  // pins
  assign swRdata     = s.rdata;
  assign pins.ceN    = !(cycBusy || s.st == H_WHR || s.st == H_POLL_WHR);
  assign pins.cle    = cle;
  assign pins.ale    = ale;
  assign pins.weN    = weN;
  assign pins.reN    = reN;
  // held low until software enables and init is done, covering power-up
  assign pins.wpN    = s.wpEn && s.initDone;
  assign pins.ioOut  = ioOut;
  assign pins.ioOe_n = ioOe_n;
endmodule // nbp_host

// File: verif/nbp_host_checker.sv
// checker: flash pin and register port properties of the host
`timescale 1ns/1ps
module nbp_host_checker #(
  parameter int PWRUP_WAIT = 20, // power-up settle cycles
  parameter int INIT_WAIT  = 20  // init busy limit cycles
) (
  input wire logic               clk_sys, // system clock
  input wire logic               nrst,    // async reset, low
  input wire nbp_pkg::nbp_req_t  swReq,   // register request
  input wire logic [31:0]        swRdata, // register read data
  input wire logic [7:0]         ioIn,    // flash bus in
  input wire logic               rbIn,    // ready/busy wire
  input wire nbp_pkg::nbp_pins_t pins     // flash pins
);
  import nbp_pkg::*;
  // ==========================================================
  // helper: edges seen with the write strobe high
  logic [3:0] weHigh;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) weHigh <= 4'h0;
    else if (!pins.weN) weHigh <= 4'h0;
    else if (weHigh != 4'hf) weHigh <= weHigh + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // strobe shapes
  sequence s_we_pulse;
    !pins.weN ##1 pins.weN;
  endsequence
  sequence s_re_pulse;
    !pins.reN ##1 pins.reN;
  endsequence
  a_strobes_exclusive: assert property (pins.weN || pins.reN)
    else $error("write and read strobes low together");
  a_we_width: assert property ($fell(pins.weN) |=> s_we_pulse)
    else $error("write strobe width wrong");
  a_re_width: assert property ($fell(pins.reN) |=> s_re_pulse)
    else $error("read strobe width wrong");
  a_write_drives_bus: assert property (!pins.weN |-> !pins.ioOe_n)
    else $error("bus not driven under write strobe");
  a_read_frees_bus: assert property (!pins.reN |-> pins.ioOe_n)
    else $error("bus driven under read strobe");
  a_strobe_under_ce: assert property
    ((!pins.weN || !pins.reN) |-> !pins.ceN)
    else $error("strobe without chip enable");
  a_latch_one_kind: assert property (!(pins.cle && pins.ale))
    else $error("command and address latch together");
  a_whr_spacing: assert property
    ($fell(pins.reN) |-> weHigh >= 4'(WHR_CYC))
    else $error("read strobe too soon after write");
  a_wp_settled: assert property
    ($rose(pins.weN) |-> pins.wpN == $past(pins.wpN, WP_CYC))
    else $error("write protect moved inside setup time");
  a_busy_status_only: assert property
    (($fell(pins.weN) && !rbIn) |-> pins.cle && pins.ioOut == CMD_STATUS)
    else $error("command other than status while busy");
  a_lock_reserved_zero: assert property
    (($past(swReq.rd) && $past(swReq.addr) == REG_LOCK)
     |-> swRdata[7:5] == 3'h0)
    else $error("reserved lock bits not zero");
endmodule // nbp_host_checker

bind nbp_host nbp_host_checker #(
  .PWRUP_WAIT(PWRUP_WAIT),
  .INIT_WAIT (INIT_WAIT)
) u_checker (
  .clk_sys(clk_sys), .nrst(nrst), .swReq(swReq), .swRdata(swRdata),
  .ioIn(ioIn), .rbIn(rbIn), .pins(pins)
);

// File: verif/nbp_flash_model.sv
// partner model: flash device answering reset, status and lock queries
`timescale 1ns/1ps
module nbp_flash_model (
  input  wire logic               clk_sys,  // bench clock, busy timing
  input  wire nbp_pkg::nbp_pins_t pins,     // host pins
  input  wire logic [15:0]        busyCyc,  // first reset busy length
  output logic [7:0]              ioIn,     // device data drive
  output logic                    rbDrvLow, // ready/busy pull-down
  output logic [7:0]              firstCmd, // first command taken
  output logic [7:0]              lastCmd,  // last command taken
  output logic [7:0]              cmdCount, // commands taken
  output logic [23:0]             addrSeen  // address bytes, first low
);
  import nbp_pkg::*;
  logic [7:0] ioDrv = 8'h00;
  logic [7:0] ioLast = 8'h00;
  logic       reading = 1'b0;
  logic       initDone = 1'b0;
  logic [1:0] nAddr = 2'd0;
  int         busyLeft = 0;
  wire [11:0] blk = {addrSeen[17:16], addrSeen[15:8], addrSeen[7:6]};
  wire [7:0]  lockByte = {3'b000,
                          blk[11],
                          ~blk[1],
                          blk[0],
                          ~blk[2], blk[2]};
  initial {firstCmd, lastCmd, cmdCount, addrSeen} = '0;
  // ready from time zero; pulls low only while busy
  assign rbDrvLow = (busyLeft != 0);
  // released bus shows the inverse, never a stale byte
  assign ioIn = reading ? ioDrv : ~ioLast;
  always @(posedge clk_sys) begin
    if (busyLeft == 1 && !initDone) begin
      initDone = 1'b1;
      lastCmd  = CMD_READ_SETUP;
    end
    if (busyLeft != 0) busyLeft = busyLeft - 1;
  end
  always @(posedge pins.weN) begin
    if (!pins.ceN && pins.cle &&
        (busyLeft == 0 || pins.ioOut == CMD_STATUS)) begin
      lastCmd  = pins.ioOut;
      cmdCount = cmdCount + 8'h1;
      nAddr    = 2'd0;
      if (cmdCount == 8'h1) firstCmd = pins.ioOut;
      // reset busy stays far inside every interrupted-op limit
      if (pins.ioOut == CMD_RESET)
        busyLeft = initDone ? 3 : int'(busyCyc);
    end else if (!pins.ceN && pins.ale && busyLeft == 0 &&
                 nAddr != 2'd3) begin
      addrSeen[nAddr*8 +: 8] = pins.ioOut;
      nAddr = nAddr + 2'd1;
    end
  end
  always @(negedge pins.reN) begin
    #1; // chip enable moves in the same step as the strobe
    if (!pins.ceN) begin
      if (lastCmd == CMD_PROT_STATUS) ioDrv = lockByte;
      else ioDrv = {pins.wpN, busyLeft == 0, 6'h00};
      reading = 1'b1;
    end
  end
  always @(posedge pins.reN) begin
    if (reading) ioLast = ioDrv;
    reading = 1'b0;
  end
endmodule // nbp_flash_model

// File: verif/nbp_host_bench.sv
// bench: register-driven checks of the flash protection host
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module nbp_host_bench;
  import nbp_pkg::*;
  localparam int WAITS = 20;
  logic        clk_sys, nrst, rbIn, rbDrvLow;
  nbp_req_t    swReq;
  nbp_pins_t   pins;
  logic [31:0] swRdata, d, expL;
  logic [7:0]  ioIn, firstCmd, lastCmd, cmdCount;
  logic [23:0] addrSeen;
  logic [15:0] busyCyc;
  logic [11:0] b;
  logic [11:0] blks [3] = '{12'hfff, 12'h001, 12'ha5e};
  int          fails, comparisons;
  always #5 clk_sys = ~clk_sys;
  assign rbIn = rbDrvLow ? 1'b0 : 1'b1; // pull-up on the shared line
  nbp_host #(.PWRUP_WAIT(WAITS), .INIT_WAIT(WAITS)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .swReq(swReq), .swRdata(swRdata),
    .ioIn(ioIn), .rbIn(rbIn), .pins(pins));
  nbp_flash_model u_flash (
    .clk_sys(clk_sys), .pins(pins), .busyCyc(busyCyc), .ioIn(ioIn),
    .rbDrvLow(rbDrvLow), .firstCmd(firstCmd), .lastCmd(lastCmd),
    .cmdCount(cmdCount), .addrSeen(addrSeen));
  // ==========================================================
  // register port tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    swReq.addr  <= a;
    swReq.wdata <= v;
    swReq.wr    <= 1'b1;
    @(posedge clk_sys);
    swReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    swReq.addr <= a;
    swReq.rd   <= 1'b1;
    @(posedge clk_sys);
    swReq.rd <= 1'b0;
    #1 v = swRdata;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0) begin
      rd(REG_STATUS, d);
      n++;
      if (n > 400) begin
        fails++;
        $display("Error idle expected 0 seen 1");
        print_verdict();
      end
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    swReq = '0;
    busyCyc = 16'd150; // outlasts the host's init wait on purpose
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 `CHECK("wpN at power-up", 1'b0, pins.wpN);
    rd(REG_STATUS, d);
    `CHECK("power-up wait", 1'b1, d[0]);
    rd(REG_LOCK, d);
    `CHECK("lock default", 32'h0000000e, d);
    wait_idle();
    wr(REG_CTRL, 32'h1 << CTRL_GO_PROT);
    repeat (WAITS) @(posedge clk_sys);
    `CHECK("commands before reset", 8'h00, cmdCount);
    wr(REG_CTRL, 32'h1 << CTRL_GO_RESET);
    wait_idle();
    `CHECK("first command", CMD_RESET, firstCmd);
    `CHECK("busy line", 1'b0, rbIn);
    rd(REG_STATUS, d);
    `CHECK("reset timeout", 5'h18, d[4:0]);
    wr(REG_CTRL, 32'h1 << CTRL_GO_POLL);
    wait_idle();
    `CHECK("status command", CMD_STATUS, lastCmd);
    rd(REG_DEVST, d);
    `CHECK("status in busy", 8'h00, d[7:0]);
    for (int i = 0; i < 300 && rbIn !== 1'b1; i++) @(posedge clk_sys);
    `CHECK("ready after init", 1'b1, rbIn);
    if (rbIn !== 1'b1) print_verdict();
    `CHECK("read setup state", CMD_READ_SETUP, lastCmd);
    wr(REG_CTRL, (32'h1 << CTRL_GO_POLL) | (32'h1 << CTRL_MULTI));
    wait_idle();
    `CHECK("enhanced status", CMD_STATUS_ENH, lastCmd);
    rd(REG_DEVST, d);
    `CHECK("ready status", 8'h40, d[7:0]);
    rd(REG_STATUS, d);
    `CHECK("init done", 1'b1, d[2]);
    foreach (blks[i]) begin
      b = blks[i];
      expL = {27'h0, b[11], ~b[1], b[0], ~b[2], b[2]};
      wr(REG_BLOCK, {20'h0, b});
      wr(REG_CTRL, (32'h1 << CTRL_GO_PROT) | (32'h1 << CTRL_WP_EN));
      wait_idle();
      `CHECK("query command", CMD_PROT_STATUS, lastCmd);
      `CHECK("address bytes", {6'h0, b[11:2], b[1:0], 6'h0}, addrSeen);
      rd(REG_LOCK, d);
      `CHECK("lock byte", expL, d);
      `CHECK("wp level", 1'b1, pins.wpN);
    end
    rd(REG_CTRL, d);
    `CHECK("control readback", 32'h00000008, d);
    rd(REG_BLOCK, d);
    `CHECK("block readback", 32'h00000a5e, d);
    rd(8'h14, d);
    `CHECK("unmapped read", 32'h0, d);
    wr(REG_CTRL, 32'h0);
    #1 `CHECK("wp dropped", 1'b0, pins.wpN);
    print_verdict();
  end
endmodule // nbp_host_bench
